// ---- verilog/abo_pkg.sv ----
// Package for the bias/offset, persistent-memory and soft-reset block.
// Assumes a single 10 MHz core clock and a byte-wide register port.
package abo_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_CMD        = 7'h7e;
    localparam logic [6:0] ADDR_PWR_CFG    = 7'h7c;
    localparam logic [6:0] ADDR_BIAS_Z     = 7'h73;
    localparam logic [6:0] ADDR_BIAS_Y     = 7'h72;
    localparam logic [6:0] ADDR_BIAS_X     = 7'h71;
    localparam logic [6:0] ADDR_PERSIST    = 7'h70;
    localparam logic [6:0] ADDR_PROG_CFG   = 7'h6a;
    localparam logic [6:0] ADDR_STATUS     = 7'h03;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         BIT_ADV_PS      = 0;
    localparam int         BIT_PROG_UNLOCK = 1;
    localparam int         BIT_COMP_EN     = 3;
    localparam int         BIT_CMD_RDY     = 4;
    localparam logic [7:0] RST_PWR_CFG     = 8'h03;
    localparam logic [7:0] RST_ZERO        = 8'h00;

    // ------------------------------------------------------------------
    // Commands and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SOFT_RESET  = 8'hb6;
    localparam logic [7:0] CMD_PROG        = 8'ha0;
    localparam int         CLK_NS          = 100;
    localparam int         LOAD_NS         = 1000;
    localparam int         PROG_NS         = 5000;
    localparam int         SRST_DELAY_NS   = 2000;
    localparam int         LOAD_CYC        = (LOAD_NS / CLK_NS < 1) ? 1 : LOAD_NS / CLK_NS;
    localparam int         PROG_CYC        = (PROG_NS / CLK_NS < 1) ? 1 : PROG_NS / CLK_NS;
    localparam int         SRST_CYC        = (SRST_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int         NV_WORDS        = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SRST = 3'b000,
        ST_LOAD = 3'b001,
        ST_IDLE = 3'b011,
        ST_PROG = 3'b010
    } abo_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [7:0]  wdata;
    } abo_req_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } abo_smp_t;

endpackage

// ---- verilog/abo_sat_add.sv ----
// Saturating adder of one axis sample and its bias correction.
// Assumes sample and bias are two's complement and the bias fits the sample.
`timescale 1ns/100ps
`default_nettype none
module abo_sat_add #(
    parameter int W = 12
) (
    input  wire logic [W-1:0] smp_i,
    input  wire logic [7:0]   bias_i,
    input  wire logic         en_i,
    output logic      [W-1:0] res_o
);
    logic [W:0] sum;
    localparam logic [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
    localparam logic [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};

    // ------------------------------------------------------------------
    // Add with clamp
    // ------------------------------------------------------------------
    always_comb begin
        sum = {smp_i[W-1], smp_i} + {{(W-7){bias_i[7]}}, bias_i};
        if (!en_i) begin
            res_o = smp_i;
        end else if (sum[W] != sum[W-1]) begin
            res_o = sum[W] ? MINV : MAXV;
        end else begin
            res_o = sum[W-1:0];
        end
    end
endmodule
`default_nettype wire

// ---- verilog/abo_ctrl.sv ----
// Bias correction, persistent-memory image control and soft reset.
// Assumes host requests arrive synchronous to core_clk_i, one per cycle.
// Behaviour
// - Bias from host registers, applied to raw and filtered streams
// - Clamp corrected sample on overflow
// - Bias registers are signed 8-bit
// - Step 3.9 mg, span half g
// - Correct only when compensation enabled
// - Sample after bias write is invalid
// - Image update copies memory to registers
// - Persist register and biases have memory backup
// - Load after reset, ready low meanwhile
// - Programming rewrites the whole memory
// - Ready low during programming, high after
// - Program only when power-save clear
// - No register access during boot
// - Busy: drop writes, reads give status
// - Command 0xb6 starts soft reset
// - Soft reset restores defaults and memory
`timescale 1ns/100ps
`default_nettype none
module abo_ctrl #(
    parameter int W = 12
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire abo_pkg::abo_req_t req_i,
    input  wire abo_pkg::abo_smp_t raw_i,
    input  wire abo_pkg::abo_smp_t filt_i,
    output logic [7:0]             rdata_o,
    output logic                   rvalid_o,
    output logic                   cmd_rdy_o,
    output abo_pkg::abo_smp_t      raw_o,
    output abo_pkg::abo_smp_t      filt_o
);
    abo_pkg::abo_state_t state_r;
    logic [15:0] cnt_r;
    logic [7:0]  nv_mem_r [abo_pkg::NV_WORDS];
    logic [7:0]  bias_r   [3];
    logic [7:0]  persist_r;
    logic [7:0]  pwr_r;
    logic [7:0]  prog_cfg_r;
    logic        skip_r;
    logic        busy;
    logic        wr_ok;
    logic        bias_wr;
    logic [7:0]  status;
    logic [W-1:0] cr [3];
    logic [W-1:0] cf [3];
    logic [W-1:0] rv [3];
    logic [W-1:0] fv [3];

    assign busy    = (state_r != abo_pkg::ST_IDLE);
    assign wr_ok   = req_i.wr && !busy;
    assign bias_wr = wr_ok && (req_i.addr == abo_pkg::ADDR_BIAS_X ||
                               req_i.addr == abo_pkg::ADDR_BIAS_Y ||
                               req_i.addr == abo_pkg::ADDR_BIAS_Z);
    assign status  = {3'h0, !busy, 4'h0};

    // ------------------------------------------------------------------
    // Sequencer: soft-reset delay, load, idle, program
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= abo_pkg::ST_LOAD;
            cnt_r   <= 16'(abo_pkg::LOAD_CYC);
        end else begin
            case (state_r)
                abo_pkg::ST_SRST: begin
                    if (cnt_r <= 16'h0001) begin
                        state_r <= abo_pkg::ST_LOAD;
                        cnt_r   <= 16'(abo_pkg::LOAD_CYC);
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                abo_pkg::ST_LOAD, abo_pkg::ST_PROG: begin
                    if (cnt_r <= 16'h0001) begin
                        state_r <= abo_pkg::ST_IDLE;
                        cnt_r   <= 16'h0000;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                abo_pkg::ST_IDLE: begin
                    if (wr_ok && req_i.addr == abo_pkg::ADDR_CMD) begin
                        if (req_i.wdata == abo_pkg::CMD_SOFT_RESET) begin
                            state_r <= abo_pkg::ST_SRST;
                            cnt_r   <= 16'(abo_pkg::SRST_CYC);
                        end else if (req_i.wdata == abo_pkg::CMD_PROG &&
                                     !pwr_r[abo_pkg::BIT_ADV_PS] &&
                                     prog_cfg_r[abo_pkg::BIT_PROG_UNLOCK]) begin
                            state_r <= abo_pkg::ST_PROG;
                            cnt_r   <= 16'(abo_pkg::PROG_CYC);
                        end
                    end
                end
                default: begin
                    state_r <= abo_pkg::ST_LOAD;
                    cnt_r   <= 16'(abo_pkg::LOAD_CYC);
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Persistent memory contents
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < abo_pkg::NV_WORDS; i++) begin
                nv_mem_r[i] <= abo_pkg::RST_ZERO;
            end
        end else if (state_r == abo_pkg::ST_IDLE && wr_ok &&
                     req_i.addr == abo_pkg::ADDR_CMD &&
                     req_i.wdata == abo_pkg::CMD_PROG &&
                     !pwr_r[abo_pkg::BIT_ADV_PS] &&
                     prog_cfg_r[abo_pkg::BIT_PROG_UNLOCK]) begin
            nv_mem_r[0] <= persist_r;
            nv_mem_r[1] <= bias_r[0];
            nv_mem_r[2] <= bias_r[1];
            nv_mem_r[3] <= bias_r[2];
        end
    end

    // ------------------------------------------------------------------
    // Image and configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            persist_r  <= abo_pkg::RST_ZERO;
            pwr_r      <= abo_pkg::RST_PWR_CFG;
            prog_cfg_r <= abo_pkg::RST_ZERO;
            for (int i = 0; i < 3; i++) begin
                bias_r[i] <= abo_pkg::RST_ZERO;
            end
        end else if (state_r == abo_pkg::ST_SRST) begin
            pwr_r      <= abo_pkg::RST_PWR_CFG;
            prog_cfg_r <= abo_pkg::RST_ZERO;
        end else if (state_r == abo_pkg::ST_LOAD) begin
            persist_r <= nv_mem_r[0];
            bias_r[0] <= nv_mem_r[1];
            bias_r[1] <= nv_mem_r[2];
            bias_r[2] <= nv_mem_r[3];
        end else if (wr_ok) begin
            case (req_i.addr)
                abo_pkg::ADDR_PERSIST:  persist_r  <= req_i.wdata;
                abo_pkg::ADDR_PWR_CFG:  pwr_r      <= req_i.wdata;
                abo_pkg::ADDR_PROG_CFG: prog_cfg_r <= req_i.wdata;
                abo_pkg::ADDR_BIAS_X:   bias_r[0]  <= req_i.wdata;
                abo_pkg::ADDR_BIAS_Y:   bias_r[1]  <= req_i.wdata;
                abo_pkg::ADDR_BIAS_Z:   bias_r[2]  <= req_i.wdata;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o   <= abo_pkg::RST_ZERO;
            rvalid_o  <= 1'b0;
            cmd_rdy_o <= 1'b0;
        end else begin
            rvalid_o  <= req_i.rd;
            cmd_rdy_o <= !busy;
            if (busy) begin
                rdata_o <= status;
            end else begin
                case (req_i.addr)
                    abo_pkg::ADDR_PERSIST:  rdata_o <= persist_r;
                    abo_pkg::ADDR_PWR_CFG:  rdata_o <= pwr_r;
                    abo_pkg::ADDR_PROG_CFG: rdata_o <= prog_cfg_r;
                    abo_pkg::ADDR_BIAS_X:   rdata_o <= bias_r[0];
                    abo_pkg::ADDR_BIAS_Y:   rdata_o <= bias_r[1];
                    abo_pkg::ADDR_BIAS_Z:   rdata_o <= bias_r[2];
                    default:                rdata_o <= status;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Bias correction datapath
    // ------------------------------------------------------------------
    assign rv[0] = raw_i.x;
    assign rv[1] = raw_i.y;
    assign rv[2] = raw_i.z;
    assign fv[0] = filt_i.x;
    assign fv[1] = filt_i.y;
    assign fv[2] = filt_i.z;

    for (genvar a = 0; a < 3; a++) begin : g_axis
        abo_sat_add #(.W(W)) u_raw (
            .smp_i  (rv[a]),
            .bias_i (bias_r[a]),
            .en_i   (persist_r[abo_pkg::BIT_COMP_EN]),
            .res_o  (cr[a])
        );
        abo_sat_add #(.W(W)) u_filt (
            .smp_i  (fv[a]),
            .bias_i (bias_r[a]),
            .en_i   (persist_r[abo_pkg::BIT_COMP_EN]),
            .res_o  (cf[a])
        );
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            skip_r <= 1'b0;
        end else if (bias_wr) begin
            skip_r <= 1'b1;
        end else if (raw_i.valid) begin
            skip_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            raw_o  <= '0;
            filt_o <= '0;
        end else begin
            raw_o  <= {raw_i.valid && !skip_r && !bias_wr, cr[0], cr[1], cr[2]};
            filt_o <= {filt_i.valid && !skip_r && !bias_wr, cf[0], cf[1], cf[2]};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_busy_ready;
        @(posedge core_clk_i) disable iff (rst_i)
        busy |=> !cmd_rdy_o;
    endproperty
    a_busy_ready: assert property (p_busy_ready) else $error("ready high while busy");

    property p_busy_read;
        @(posedge core_clk_i) disable iff (rst_i)
        (busy && req_i.rd) |=> (rdata_o == $past(status));
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy read not status");

    property p_srst;
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_ok && req_i.addr == abo_pkg::ADDR_CMD &&
         req_i.wdata == abo_pkg::CMD_SOFT_RESET) |=> (state_r == abo_pkg::ST_SRST);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not taken");

    property p_ps_block;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == abo_pkg::ST_IDLE && pwr_r[abo_pkg::BIT_ADV_PS]) |=>
        (state_r != abo_pkg::ST_PROG);
    endproperty
    a_ps_block: assert property (p_ps_block) else $error("program under power save");

    property p_skip;
        @(posedge core_clk_i) disable iff (rst_i)
        bias_wr |=> !raw_o.valid;
    endproperty
    a_skip: assert property (p_skip) else $error("sample after bias write valid");

    property p_bypass;
        @(posedge core_clk_i) disable iff (rst_i)
        !persist_r[abo_pkg::BIT_COMP_EN] |-> (cr[0] == rv[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bias applied while disabled");

    property p_drop_wr;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == abo_pkg::ST_PROG && req_i.wr) |=> $stable(pwr_r);
    endproperty
    a_drop_wr: assert property (p_drop_wr) else $error("write taken while busy");

    property p_load;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == abo_pkg::ST_LOAD) |=> (bias_r[0] == $past(nv_mem_r[1]));
    endproperty
    a_load: assert property (p_load) else $error("image not loaded");

    property p_prog_copy;
        @(posedge core_clk_i) disable iff (rst_i)
        (state_r == abo_pkg::ST_IDLE) ##1 (state_r == abo_pkg::ST_PROG) |->
        (nv_mem_r[0] == $past(persist_r) && nv_mem_r[1] == $past(bias_r[0]) &&
         nv_mem_r[2] == $past(bias_r[1]) && nv_mem_r[3] == $past(bias_r[2]));
    endproperty
    a_prog_copy: assert property (p_prog_copy) else $error("memory not fully rewritten");

    property p_bad_cmd;
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_ok && req_i.addr == abo_pkg::ADDR_CMD &&
         req_i.wdata != abo_pkg::CMD_SOFT_RESET && req_i.wdata != abo_pkg::CMD_PROG) |=>
        (state_r == abo_pkg::ST_IDLE);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("undefined command acted on");

    c_prog: cover property (@(posedge core_clk_i) state_r == abo_pkg::ST_PROG);
    c_srst: cover property (@(posedge core_clk_i) state_r == abo_pkg::ST_SRST);
    c_clamp: cover property (@(posedge core_clk_i) raw_o.valid && raw_o.x == 12'h7ff);
endmodule
`default_nettype wire

// ---- verification/abo_host.sv ----
// Host model driving the register port of the bias block.
// Assumes its tasks are called at a falling edge of core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module abo_host (
    input  wire logic             core_clk_i,
    input  wire logic [7:0]       rdata_i,
    input  wire logic             rvalid_i,
    input  wire logic             cmd_rdy_i,
    output var abo_pkg::abo_req_t req_o
);
    initial req_o = '0;
    // ------------------------------------------------------------
    // Single accesses, held one cycle, then released
    // ------------------------------------------------------------
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        req_o = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk_i);
        q = rdata_i;
        v = rvalid_i;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(negedge core_clk_i);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       v;
        access(1'b1, a, d, q, v);
    endtask
    task automatic wait_rdy(input int n, output logic ok);
        ok = cmd_rdy_i;
        while (ok !== 1'b1 && n > 0) begin
            @(negedge core_clk_i);
            n--;
            ok = cmd_rdy_i;
        end
    endtask
    // ------------------------------------------------------------
    // Memory sequences
    // ------------------------------------------------------------
    task automatic nvm_prog(input logic [7:0] p, bx, by, bz);
        wr(abo_pkg::ADDR_PWR_CFG, 8'h00);
        wr(abo_pkg::ADDR_PERSIST, p);
        wr(abo_pkg::ADDR_BIAS_X, bx);
        wr(abo_pkg::ADDR_BIAS_Y, by);
        wr(abo_pkg::ADDR_BIAS_Z, bz);
        wr(abo_pkg::ADDR_PROG_CFG, 8'h02);
        wr(abo_pkg::ADDR_CMD, abo_pkg::CMD_PROG);
    endtask
    task automatic nvm_lock(output logic ok);
        wait_rdy(200, ok);
        wr(abo_pkg::ADDR_PROG_CFG, 8'h00);
    endtask
    task automatic soft_rst(output logic ok);
        wait_rdy(200, ok);
        wr(abo_pkg::ADDR_CMD, abo_pkg::CMD_SOFT_RESET);
    endtask
endmodule
`default_nettype wire

// ---- verification/abo_ctrl_test.sv ----
// Self-checking bench for the bias, memory image and soft reset block.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/100ps
`default_nettype none
module abo_ctrl_test;
    logic              core_clk_i = 1'b0;
    logic              rst_i      = 1'b1;
    abo_pkg::abo_req_t req;
    abo_pkg::abo_smp_t raw_i      = '0;
    abo_pkg::abo_smp_t filt_i     = '0;
    abo_pkg::abo_smp_t raw_o;
    abo_pkg::abo_smp_t filt_o;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              cmd_rdy;
    logic              ok;
    logic [7:0]        bias [3];
    logic [31:0]       seed       = 32'hb06b417f;
    int                errors     = 0;
    int                checks     = 0;
    int                i;

    always #50 core_clk_i = ~core_clk_i;

    abo_ctrl u_abo_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .raw_i(raw_i),
        .filt_i(filt_i), .rdata_o(rdata), .rvalid_o(rvalid), .cmd_rdy_o(cmd_rdy),
        .raw_o(raw_o), .filt_o(filt_o));
    abo_host u_abo_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .cmd_rdy_i(cmd_rdy), .req_o(req));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_smp(input string what, input logic [36:0] exp, input logic [36:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ------------------------------------------------------------
    // Expectations and stimulus helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction
    function automatic logic [11:0] sat(input logic [11:0] s, input logic [7:0] b, input logic en);
        logic signed [12:0] t;
        t = $signed({s[11], s}) + $signed({{5{b[7]}}, b});
        if (!en) return s;
        if (t > 13'sd2047) return 12'h7ff;
        if (t < -13'sd2048) return 12'h800;
        return t[11:0];
    endfunction
    function automatic logic [36:0] corr(input logic [35:0] v, input logic en);
        return {1'b1, sat(v[35:24], bias[0], en), sat(v[23:12], bias[1], en),
                sat(v[11:0], bias[2], en)};
    endfunction
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] q;
        logic       v;
        u_abo_host.access(1'b0, a, 8'h00, q, v);
        chk_byte("rvalid", 8'h01, {7'h0, v});
        chk_byte("rdata", exp & m, q & m);
    endtask
    task automatic smp(input logic [35:0] v, input logic en, input logic vld);
        raw_i  = {1'b1, v};
        filt_i = {1'b1, ~v};
        @(negedge core_clk_i);
        raw_i.valid  = 1'b0;
        filt_i.valid = 1'b0;
        if (vld) begin
            chk_smp("raw", corr(v, en), raw_o);
            chk_smp("filt", corr(~v, en), filt_o);
        end else begin
            chk_byte("valid", 8'h00, {6'h0, raw_o.valid, filt_o.valid});
        end
    endtask
    task automatic wr_bias(input int k, input logic [7:0] b, input logic en);
        u_abo_host.wr(7'(abo_pkg::ADDR_BIAS_X + k), b);
        bias[k] = b;
        smp(36'({rnd(), rnd()}), en, 1'b0);
    endtask

    initial begin
        #(5000 * 100);
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk_byte("rdy", 8'h00, {7'h0, cmd_rdy});
        rd_chk(abo_pkg::ADDR_BIAS_X, 8'h00, 8'h10);
        u_abo_host.wait_rdy(40, ok);
        chk_byte("boot", 8'h01, {7'h0, ok});
        rd_chk(abo_pkg::ADDR_PWR_CFG, abo_pkg::RST_PWR_CFG, 8'hff);
        rd_chk(abo_pkg::ADDR_PERSIST, 8'h00, 8'hff);
        rd_chk(7'h10, 8'h10, 8'h10);
        for (i = 0; i < 3; i++) begin
            wr_bias(i, 8'(rnd()), 1'b0);
            rd_chk(7'(abo_pkg::ADDR_BIAS_X + i), bias[i], 8'hff);
            smp(36'({rnd(), rnd()}), 1'b0, 1'b1);
        end
        u_abo_host.wr(abo_pkg::ADDR_PERSIST, 8'h08);
        for (i = 0; i < 12; i++) begin
            wr_bias(i % 3, 8'(rnd()), 1'b1);
            smp(36'({rnd(), rnd()}), 1'b1, 1'b1);
        end
        wr_bias(0, 8'h7f, 1'b1);
        wr_bias(1, 8'h80, 1'b1);
        wr_bias(2, 8'h01, 1'b1);
        smp(36'h7ff_800_7ff, 1'b1, 1'b1);
        smp(36'h7c0_83f_000, 1'b1, 1'b1);
        u_abo_host.nvm_prog(8'h08, 8'h5a, 8'ha5, 8'h3c);
        chk_byte("rdy", 8'h00, {7'h0, cmd_rdy});
        u_abo_host.wr(abo_pkg::ADDR_BIAS_X, 8'h11);
        rd_chk(abo_pkg::ADDR_BIAS_Y, 8'h00, 8'h10);
        u_abo_host.nvm_lock(ok);
        chk_byte("prog", 8'h01, {7'h0, ok});
        rd_chk(abo_pkg::ADDR_BIAS_X, 8'h5a, 8'hff);
        u_abo_host.wr(abo_pkg::ADDR_BIAS_X, 8'h77);
        u_abo_host.wr(abo_pkg::ADDR_PWR_CFG, 8'h01);
        u_abo_host.wr(abo_pkg::ADDR_PROG_CFG, 8'h02);
        u_abo_host.wr(abo_pkg::ADDR_CMD, 8'h55);
        chk_byte("rdy", 8'h01, {7'h0, cmd_rdy});
        rd_chk(abo_pkg::ADDR_BIAS_X, 8'h77, 8'hff);
        u_abo_host.wr(abo_pkg::ADDR_CMD, abo_pkg::CMD_PROG);
        chk_byte("rdy", 8'h01, {7'h0, cmd_rdy});
        u_abo_host.soft_rst(ok);
        repeat (23) @(negedge core_clk_i);
        chk_byte("rdy", 8'h00, {7'h0, cmd_rdy});
        u_abo_host.wait_rdy(200, ok);
        chk_byte("srst", 8'h01, {7'h0, ok});
        rd_chk(abo_pkg::ADDR_BIAS_X, 8'h5a, 8'hff);
        rd_chk(abo_pkg::ADDR_BIAS_Y, 8'ha5, 8'hff);
        rd_chk(abo_pkg::ADDR_BIAS_Z, 8'h3c, 8'hff);
        rd_chk(abo_pkg::ADDR_PERSIST, 8'h08, 8'hff);
        rd_chk(abo_pkg::ADDR_PWR_CFG, abo_pkg::RST_PWR_CFG, 8'hff);
        rd_chk(abo_pkg::ADDR_PROG_CFG, 8'h00, 8'hff);
        tally_and_finish();
    end
endmodule
`default_nettype wire
